// ===== isk_exec.sv
// Decode and execute of increment-skip-if-zero and the two OR instructions
//
// Operation
// RULE_01 - Opcode 001111 d fffff increments file register; status flags untouched.
// RULE_02 - Increment result goes to accumulator when d is 0, file when 1.
// RULE_03 - Zero increment result discards the fetched next instruction as a no-op.
// RULE_04 - Opcode 1101 kkkkkkkk ORs the literal into the accumulator in one cycle.
// RULE_05 - Literal OR writes only the accumulator and updates the zero flag.
// RULE_06 - Opcode 000100 d fffff ORs accumulator with file; d picks destination; zero updated.
// RULE_07 - Zero flag set on all-zero OR result, else cleared; file addresses 0 to 31.
`timescale 1ns/100ps
`include "isk_regs.svh"

module isk_exec
  import isk_pkg::*;
(
  // Clock and reset
  input  wire logic                       clock_in,
  input  wire logic                       rst_n_in,
  // Instruction from fetch
  input  wire logic                       instr_valid_in,
  input  wire logic [`ISK_INSTR_W-1:0]    instr_in,
  // File register read port (combinational read data)
  output logic      [`ISK_ADDR_W-1:0]     file_addr_out,
  input  wire logic [`ISK_DATA_W-1:0]     file_rdata_in,
  // File register write port
  output logic                            file_we_out,
  output logic      [`ISK_ADDR_W-1:0]     file_waddr_out,
  output logic      [`ISK_DATA_W-1:0]     file_wdata_out,
  // Core state
  output logic      [`ISK_DATA_W-1:0]     acc_out,
  output logic                            zero_flag_out,
  output logic                            zero_we_out,
  output logic                            skip_out,
  output logic                            busy_out
);

  isk_op_t                    op;
  isk_state_t                 state_reg;
  isk_state_t                 state_next;
  logic                       dest_file;
  logic [`ISK_ADDR_W-1:0]     faddr;
  logic [`ISK_DATA_W-1:0]     lit;
  logic [`ISK_DATA_W-1:0]     result;
  logic                       accept;
  logic [`ISK_DATA_W-1:0]     acc_reg;
  logic                       is_incskip;
  logic                       is_orlit;
  logic                       is_orfile;
  logic                       writes_file;
  logic                       writes_acc;
  logic                       updates_zero;
  logic                       inc_wrapped;

  assign dest_file = instr_in[`ISK_DEST_BIT];
  assign faddr     = instr_in[`ISK_ADDR_W-1:0];                 // [RULE_07]
  assign lit       = instr_in[`ISK_DATA_W-1:0];
  // The instruction after a zero increment is dropped here, not refetched
  assign accept    = instr_valid_in && (state_reg == ISK_ST_RUN); // [RULE_03]

  // One-hot views of the decoded operation, shared by every write-back path
  assign is_incskip   = (op == ISK_OP_INCSKIP);                  // [RULE_01]
  assign is_orlit     = (op == ISK_OP_ORLIT);                    // [RULE_04]
  assign is_orfile    = (op == ISK_OP_ORFILE);                   // [RULE_06]
  // The literal OR names no file, so only the d-bit forms may write one
  assign writes_file  = (is_incskip || is_orfile) && dest_file;  // [RULE_02] [RULE_06]
  assign writes_acc   = is_orlit || ((is_incskip || is_orfile) && !dest_file); // [RULE_05]
  // Increment leaves the flag alone; only the OR forms touch it
  assign updates_zero = is_orlit || is_orfile;                   // [RULE_01] [RULE_05]
  assign inc_wrapped  = is_incskip && (result == 8'h00);         // [RULE_03]

  always_comb
  begin
    op = ISK_OP_NONE;
    if (accept)
    begin
      if (instr_in[11:6] == `ISK_OP6_INCSKIP)
        op = ISK_OP_INCSKIP;                                    // [RULE_01]
      else if (instr_in[11:8] == `ISK_OP4_ORLIT)
        op = ISK_OP_ORLIT;                                      // [RULE_04]
      else if (instr_in[11:6] == `ISK_OP6_ORFILE)
        op = ISK_OP_ORFILE;                                     // [RULE_06]
    end
  end

  always_comb
  begin
    case (op)
      ISK_OP_INCSKIP: result = file_rdata_in + 8'h01;           // [RULE_01]
      ISK_OP_ORLIT:   result = acc_reg | lit;                   // [RULE_04]
      ISK_OP_ORFILE:  result = acc_reg | file_rdata_in;         // [RULE_06]
      default:        result = acc_reg;
    endcase
  end

  always_comb
  begin
    state_next = ISK_ST_RUN;
    case (state_reg)
      ISK_ST_RUN:
      begin
        if (inc_wrapped)
          state_next = ISK_ST_SKIP;                             // [RULE_03]
      end
      ISK_ST_SKIP:
      begin
        // Stay until the discarded word has actually arrived
        if (!instr_valid_in)
          state_next = ISK_ST_SKIP;
      end
      default: state_next = ISK_ST_RUN;
    endcase
  end

  // Read address is combinational so the operand is ready this cycle
  always_comb
  begin
    file_addr_out = faddr;
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= ISK_ST_RUN;
    end
    else
    begin
      state_reg <= state_next;                                  // [RULE_03]
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      acc_reg <= `ISK_ACC_RESET;
    end
    else if (writes_acc)
    begin
      acc_reg <= result;                                        // [RULE_02] [RULE_05] [RULE_06]
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      file_we_out <= 1'b0;
    end
    else
    begin
      file_we_out <= writes_file;                               // [RULE_02]
    end
  end

  // Address and data follow every cycle; only the enable qualifies them
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      file_waddr_out <= '0;
    end
    else
    begin
      file_waddr_out <= faddr;                                  // [RULE_07]
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      file_wdata_out <= '0;
    end
    else
    begin
      file_wdata_out <= result;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      zero_we_out <= 1'b0;
    end
    else
    begin
      zero_we_out <= updates_zero;                              // [RULE_01] [RULE_05]
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      zero_flag_out <= `ISK_ZERO_RESET;
    end
    else if (updates_zero)
    begin
      zero_flag_out <= (result == 8'h00);                       // [RULE_07]
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      skip_out <= 1'b0;
    end
    else
    begin
      skip_out <= (state_next == ISK_ST_SKIP) && (state_reg == ISK_ST_RUN); // [RULE_03]
    end
  end

  // Held until the word after a zero increment has arrived and been dropped
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      busy_out <= 1'b0;
    end
    else
    begin
      busy_out <= (state_next == ISK_ST_SKIP);                  // [RULE_03]
    end
  end

  assign acc_out = acc_reg;

endmodule : isk_exec

// ===== isk_regs.svh
// Constants for the increment-skip and OR instruction decoder
`ifndef ISK_REGS_SVH
`define ISK_REGS_SVH
`define ISK_INSTR_W        12
`define ISK_DATA_W         8
`define ISK_ADDR_W         5
`define ISK_OP6_INCSKIP    6'h0F
`define ISK_OP6_ORFILE     6'h04
`define ISK_OP4_ORLIT      4'hD
`define ISK_DEST_BIT       5
`define ISK_ACC_RESET      8'h00
`define ISK_ZERO_RESET     1'b0
`endif

// ===== isk_pkg.sv
// Types for the increment-skip and OR instruction decoder
package isk_pkg;
  typedef enum logic [1:0]
  {
    ISK_OP_NONE,
    ISK_OP_INCSKIP,
    ISK_OP_ORLIT,
    ISK_OP_ORFILE
  } isk_op_t;
  typedef enum logic
  {
    ISK_ST_RUN,
    ISK_ST_SKIP
  } isk_state_t;
endpackage : isk_pkg

// ===== isk_exec_asserts.sv
// Port checker for the decoder
`timescale 1ns/100ps
module isk_exec_chk (
  input wire logic        clock_in, rst_n_in, instr_valid_in, file_we_out,
  input wire logic        zero_flag_out, zero_we_out, skip_out, busy_out,
  input wire logic [11:0] instr_in,
  input wire logic [4:0]  file_addr_out, file_waddr_out,
  input wire logic [7:0]  file_rdata_in, file_wdata_out, acc_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  wire t   = instr_valid_in && !busy_out;
  wire inc = t && instr_in[11:6] == 6'h0F;
  wire orf = t && instr_in[11:6] == 6'h04;
  wire orl = t && instr_in[11:8] == 4'hD;
  a_inc_acc: assert property (inc && !instr_in[5] |=>
    acc_out == $past(file_rdata_in) + 8'h01) else $error("inc acc");
  a_inc_file: assert property (inc && instr_in[5] |=>
    file_we_out && file_wdata_out == $past(file_rdata_in) + 8'h01) else $error("inc file");
  a_inc_flag: assert property (inc |=> !zero_we_out && $stable(zero_flag_out))
    else $error("inc flag");
  a_inc_skip: assert property (inc |=> skip_out == ($past(file_rdata_in) == 8'hFF))
    else $error("skip");
  a_skip_drop: assert property (busy_out && instr_valid_in |=>
    !file_we_out && $stable(acc_out)) else $error("drop");
  a_orl_acc: assert property (orl |=> !file_we_out &&
    acc_out == ($past(acc_out) | $past(instr_in[7:0]))) else $error("orl");
  a_orf_dest: assert property (orf |=> file_we_out == $past(instr_in[5]))
    else $error("orf dest");
  a_or_zero: assert property (orl || orf && !instr_in[5] |=>
    zero_we_out && zero_flag_out == (acc_out == 8'h00)) else $error("zero");
  cover property (inc ##1 skip_out);
  cover property (orl ##1 zero_flag_out);
  cover property (orf && instr_in[5]);
endmodule : isk_exec_chk

// ===== isk_file_model.sv
// File register model
`timescale 1ns/100ps
module isk_file_model (
  input wire logic       clock_in, we_in,
  input wire logic [4:0] ra_in, wa_in,
  input wire logic [7:0] wd_in,
  output logic     [7:0] rd_out
);
  logic [7:0] mem [32];
  initial for (int i = 0; i < 32; i++) mem[i] = 8'(i * 17);
  // Bypass, so a read right after a write sees the new value
  assign rd_out = (we_in && wa_in == ra_in) ? wd_in : mem[ra_in];
  // Plain always, since the initial block above also writes the array
  always @(posedge clock_in) if (we_in) mem[wa_in] <= wd_in;
endmodule : isk_file_model

// ===== isk_exec_tb_top.sv
// Testbench for the decoder
`timescale 1ns/100ps
module isk_exec_tb_top;
  logic        clock_in = 0, rst_n_in = 0, instr_valid_in = 0, on = 0, ez = 0, es = 0, dp = 0;
  logic        file_we_out, zero_flag_out, zero_we_out, skip_out, busy_out;
  logic [11:0] instr_in = 0;
  logic [4:0]  file_addr_out, file_waddr_out;
  logic [7:0]  file_rdata_in, file_wdata_out, acc_out, ea = 0, fx [32];
  int          error_cnt = 0, compares = 0, cyc = 0;
  logic [11:0] w_c [7] = '{12'hD00, 12'h3CF, 12'hDFF, 12'hD35, 12'h133, 12'h12F, 12'h3EF};
  initial forever #4 clock_in = ~clock_in;
  isk_exec dut (.clock_in, .rst_n_in, .instr_valid_in, .instr_in, .file_addr_out, .file_rdata_in,
    .file_we_out, .file_waddr_out, .file_wdata_out, .acc_out, .zero_flag_out, .zero_we_out,
    .skip_out, .busy_out);
  isk_file_model fm (.clock_in, .we_in(file_we_out), .ra_in(file_addr_out),
    .wa_in(file_waddr_out), .wd_in(file_wdata_out), .rd_out(file_rdata_in));
  task automatic chk(input logic [7:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic void pred(input logic [11:0] w);
    logic [7:0] r;
    r = fx[w[4:0]];
    if (dp) dp = 0;
    else if (w[11:6] == 6'h0F)
    begin
      r = r + 8'h01;
      if (w[5]) fx[w[4:0]] = r; else ea = r;
      es = (r == 8'h00);
      dp = es;
    end
    else if (w[11:8] == 4'hD)
    begin
      ea = ea | w[7:0];
      ez = (ea == 8'h00);
    end
    else if (w[11:6] == 6'h04)
    begin
      r = r | ea;
      if (w[5]) fx[w[4:0]] = r; else ea = r;
      ez = (r == 8'h00);
    end
  endfunction : pred
  task automatic run(input logic [11:0] w, input logic v);
    instr_in <= w;
    instr_valid_in <= v;
    @(posedge clock_in);
    es = 0;
    if (v) pred(w);
  endtask : run
  always @(negedge clock_in)
    if (on)
    begin
      chk(acc_out, ea);
      chk(zero_flag_out, ez);
      chk(skip_out, es);
    end
  task automatic complete_run();
    $display("mismatches %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  always @(posedge clock_in)
    if (++cyc > 1000)
    begin
      error_cnt++;
      complete_run();
    end
  initial
  begin
    int k;
    logic [11:0] w;
    k = $urandom(32'h9227);
    for (int i = 0; i < 32; i++) fx[i] = 8'(i * 17);
    repeat (5) @(posedge clock_in);
    rst_n_in <= 1;
    on = 1;
    // Zero OR, wrap to zero with a dropped word, then back-to-back ORs
    foreach (w_c[i]) run(w_c[i], 1);
    $display("corner test done");
    repeat (300)
    begin
      k = $urandom % 4;
      w = 12'($urandom);
      if (k == 0) w[11:6] = 6'h0F;
      if (k == 1) w[11:8] = 4'hD;
      if (k == 2) w[11:6] = 6'h04;
      run(w, $urandom % 8 != 0);
    end
    $display("random test done");
    repeat (2) run(12'h000, 0);
    for (int i = 0; i < 32; i++) chk(fm.mem[i], fx[i]);
    complete_run();
  end
endmodule : isk_exec_tb_top
bind isk_exec isk_exec_chk u_chk (.clock_in, .rst_n_in, .instr_valid_in, .file_we_out,
  .zero_flag_out, .zero_we_out, .skip_out, .busy_out, .instr_in, .file_addr_out,
  .file_waddr_out, .file_rdata_in, .file_wdata_out, .acc_out);
